// *** testbench/sfre_host_model.sv ***
// Host controller model driving the flash pins
`timescale 1ns/100ps
`default_nettype none
module sfre_host_model (
  input  wire logic [3:0] i_dq,
  input  wire logic [3:0] i_dq_oe,
  output var  logic       o_sclk,
  output var  logic       o_cs_n,
  output var  logic [3:0] o_dq,
  output var  logic       o_dq_oe
);
  logic [63:0] rx;
  logic        seen;
  logic        pre;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq = 4'h0;
    o_dq_oe = 1'b0;
  end
  // Samples late in the high phase, well after the device output settles
  task automatic tick(input logic [3:0] d, input int w, input logic r);
    o_dq = d;
    #400 o_sclk = 1'b1;
    #300 seen = seen | (|i_dq_oe);
    rx = (w == 1) ? {rx[62:0], i_dq[1]} :
         (w == 2) ? {rx[61:0], i_dq[1:0]} : {rx[59:0], i_dq};
    if (r) o_dq_oe = 1'b0;
    #100 o_sclk = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w,
                      input logic r);
    for (int i = n - w; i >= 0; i -= w)
      tick(4'((v >> i) & ((32'h1 << w) - 32'h1)), 0, r && i == 0);
  endtask
  task automatic frame(input logic [7:0] c, input int cw,
                       input logic [23:0] a, input int aw,
                       input logic [7:0] m, input int mw, input int nd,
                       input int nclk, input int dw);
    seen = 1'b0;
    o_dq_oe = 1'b1;
    o_cs_n = 1'b0;
    #400;
    if (cw > 0) send(32'(c), 8, cw, 1'b0);
    send(32'(a), 24, aw, nd == 0 && mw == 0);
    if (mw > 0) send(32'(m), 8, mw, nd == 0);
    repeat (nd) tick(4'h0, 1, 1'b1);
    pre = seen;
    rx = 64'h0;
    repeat (nclk) tick(4'h0, dw, 1'b1);
    o_cs_n = 1'b1;
    #800;
  endtask
endmodule
`default_nettype wire

// *** testbench/sfre_read_engine_checker.sv ***
// Port assertions for the serial flash read engine
`timescale 1ns/100ps
`default_nettype none
module sfre_read_engine_checker (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RESET,
  input wire logic        I_SCLK,
  input wire logic        I_CS_N,
  input wire logic        I_BUSY,
  input wire logic        I_QUAD_EN,
  input wire logic        I_FOUR_LINE_MODE,
  input wire logic [3:0]  O_DQ_OE,
  input wire logic [23:0] O_MEM_ADDR,
  input wire logic        O_SKIP_MODE,
  input wire logic        O_DATA_PHASE
);
  logic       sclk_q;
  logic [3:0] since_q;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  // Counts from falls only, so output launched on a rise shows as late
  always_ff @(posedge I_CLK_SYS) begin
    sclk_q <= I_SCLK;
    if (I_RESET || (sclk_q && !I_SCLK)) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  sequence s_cs_idle;
    I_CS_N [*6];
  endsequence
  a_oe_in_data: assert property (O_DQ_OE != 4'h0 |-> O_DATA_PHASE)
    else $error("lanes driven outside data phase");
  a_oe_lane_set: assert property (O_DQ_OE != 4'h0 |->
    O_DQ_OE inside {4'h2, 4'h3, 4'hF}) else $error("bad lane enables");
  a_cs_release: assert property (s_cs_idle |->
    O_DQ_OE == 4'h0 && !O_DATA_PHASE) else $error("lanes held after select");
  a_quad_needs_qe: assert property ((O_DQ_OE == 4'hF) &&
    !I_FOUR_LINE_MODE |-> I_QUAD_EN) else $error("quad without enable");
  a_addr_step: assert property (O_DATA_PHASE && $past(O_DATA_PHASE) &&
    $changed(O_MEM_ADDR) |-> O_MEM_ADDR == $past(O_MEM_ADDR) + 24'h1)
    else $error("address step not one");
  a_busy_block: assert property (I_BUSY && !O_DATA_PHASE |=>
    !O_DATA_PHASE) else $error("read accepted while busy");
  a_skip_in_frame: assert property ($changed(O_SKIP_MODE) |->
    !I_CS_N && !$past(O_DATA_PHASE))
    else $error("skip changed outside mode phase");
  a_first_on_fall: assert property ($rose(O_DQ_OE != 4'h0) |->
    since_q < 4'h6) else $error("first data not on a fall");
endmodule
bind sfre_read_engine sfre_read_engine_checker u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_SCLK(I_SCLK),
  .I_CS_N(I_CS_N), .I_BUSY(I_BUSY), .I_QUAD_EN(I_QUAD_EN),
  .I_FOUR_LINE_MODE(I_FOUR_LINE_MODE), .O_DQ_OE(O_DQ_OE),
  .O_MEM_ADDR(O_MEM_ADDR), .O_SKIP_MODE(O_SKIP_MODE),
  .O_DATA_PHASE(O_DATA_PHASE));
`default_nettype wire

// *** testbench/tb_sfre_read_engine.sv ***
// Self-checking bench for the serial flash read engine
`timescale 1ns/100ps
`default_nettype none
module tb_sfre_read_engine;
  logic        clk;
  logic        rst;
  logic        busy;
  logic        qe;
  logic        four_line_command_mode;
  logic        pwe;
  logic [1:0]  par;
  logic [3:0]  dq_in;
  logic [3:0]  dq_out;
  logic [3:0]  dq_oe;
  logic [23:0] addr;
  logic [7:0]  mdata;
  logic        skip;
  logic        dphase;
  logic        h_sclk;
  logic        h_cs_n;
  logic [3:0]  h_dq;
  logic        h_oe;
  int          n_fail;
  int          n_checks;
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  always #50 clk = ~clk;
  assign mdata = mem(addr);
  // Released lanes float to the inverse of the host's o_dq, which it sets to zero after releasing
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & (h_oe ? h_dq : ~h_dq));
  sfre_read_engine uut (.I_CLK_SYS(clk), .I_RESET(rst), .I_SCLK(h_sclk),
    .I_CS_N(h_cs_n), .I_DQ(dq_in), .I_BUSY(busy), .I_QUAD_EN(qe),
    .I_FOUR_LINE_MODE(four_line_command_mode), .I_PARAM_WE(pwe), .I_READ_PARAM(par),
    .I_MEM_DATA(mdata), .O_DQ(dq_out), .O_DQ_OE(dq_oe), .O_MEM_ADDR(addr),
    .O_SKIP_MODE(skip), .O_DATA_PHASE(dphase));
  sfre_host_model u_host (.i_dq(dq_out), .i_dq_oe(dq_oe), .o_sclk(h_sclk),
    .o_cs_n(h_cs_n), .o_dq(h_dq), .o_dq_oe(h_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, input int cw, input logic [23:0] a,
                    input int aw, input logic [7:0] m, input int mw,
                    input int nd, input int dw, input logic ok);
    u_host.frame(c, cw, a, aw, m, mw, nd, 16 / dw, dw);
    if (ok) begin
      chk(32'(u_host.rx[15:0]), {16'h0, mem(a), mem(a + 24'h1)});
      chk(32'(u_host.pre), 32'h0);
    end else begin
      chk(32'(u_host.seen), 32'h0);
    end
  endtask
  task automatic set_param(input logic [1:0] v);
    @(negedge clk) par = v;
    pwe = 1'b1;
    @(negedge clk) pwe = 1'b0;
  endtask
  task automatic t_basic;
    rd(8'h03, 1, 24'h1234FF, 1, 8'h00, 0, 0, 1, 1'b1);
    chk(32'(addr), 32'h123501);
    chk(32'(dq_oe), 32'h0);
    @(negedge clk) busy = 1'b1;
    rd(8'h03, 1, 24'h000010, 1, 8'h00, 0, 0, 1, 1'b0);
    chk(32'(addr), 32'h123501);
    @(negedge clk) busy = 1'b0;
  endtask
  task automatic t_fast;
    rd(8'h0B, 1, 24'h00ABCD, 1, 8'h00, 0, 8, 1, 1'b1);
    rd(8'h3B, 1, 24'h0F0F01, 1, 8'h00, 0, 8, 2, 1'b1);
    rd(8'h6B, 1, 24'h00C3A0, 1, 8'h00, 0, 8, 4, 1'b0);
    @(negedge clk) qe = 1'b1;
    rd(8'h6B, 1, 24'h00C3A0, 1, 8'h00, 0, 8, 4, 1'b1);
    // Double-edge address ends half way, so six later address clocks count as dummies and the rest as data
    u_host.frame(8'h0D, 1, 24'h000000, 1, 8'h00, 0, 0, 4, 1);
    chk(32'(u_host.seen), 32'h1);
  endtask
  task automatic t_qpi;
    @(negedge clk) four_line_command_mode = 1'b1;
    rd(8'h0B, 4, 24'h00F00D, 4, 8'h00, 0, 2, 4, 1'b1);
    set_param(2'h0);
    rd(8'h0B, 4, 24'h00F00E, 4, 8'h00, 0, 2, 4, 1'b1);
    for (int p = 1; p < 4; p++) begin
      set_param(2'(p));
      rd(8'h0B, 4, 24'h000100, 4, 8'h00, 0, 2 * p + 2, 4, 1'b1);
    end
    rd(8'h03, 4, 24'h000100, 4, 8'h00, 0, 0, 4, 1'b0);
    u_host.frame(8'h0D, 4, 24'h000000, 4, 8'h00, 0, 5, 4, 4);
    chk(32'(u_host.seen), 32'h1);
    @(negedge clk) four_line_command_mode = 1'b0;
  endtask
  task automatic t_dual_io;
    rd(8'hBB, 1, 24'h345678, 2, 8'h2F, 2, 0, 2, 1'b1);
    chk(32'(skip), 32'h1);
    rd(8'h00, 0, 24'h345700, 2, 8'h00, 2, 0, 2, 1'b1);
    chk(32'(skip), 32'h0);
    rd(8'hBB, 1, 24'h000200, 2, 8'hE0, 2, 0, 2, 1'b1);
    chk(32'(skip), 32'h1);
    // All ones on lane zero for sixteen clocks gives mode bits 5:4 of 01, which ends skip mode
    rd(8'h00, 0, 24'h555555, 2, 8'h55, 2, 0, 2, 1'b1);
    chk(32'(skip), 32'h0);
  endtask
  task automatic t_abort;
    u_host.frame(8'h03, 1, 24'h000400, 1, 8'h00, 0, 0, 4, 1);
    chk(32'(dq_oe), 32'h0);
    chk(32'(dphase), 32'h0);
    chk(32'(addr), 32'h000400);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {busy, qe, four_line_command_mode, pwe, par} = 6'h00;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_basic;
    t_fast;
    t_qpi;
    t_dual_io;
    t_abort;
    end_sim;
  end
  initial begin
    #3000000;
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire

// *** verilog/sfre_defines.svh ***
// Constants for the serial flash read engine
`ifndef SFRE_DEFINES_SVH
`define SFRE_DEFINES_SVH

`define SFRE_OP_READ        8'h03
`define SFRE_OP_FAST        8'h0B
`define SFRE_OP_DTR_FAST    8'h0D
`define SFRE_OP_DUAL_OUT    8'h3B
`define SFRE_OP_QUAD_OUT    8'h6B
`define SFRE_OP_DUAL_IO     8'hBB

`define SFRE_CMD_BITS       5'h08
`define SFRE_ADDR_BITS      5'h18
`define SFRE_MODE_BITS      5'h08
`define SFRE_BYTE_BITS      4'h8

`define SFRE_LANES_1        3'h1
`define SFRE_LANES_2        3'h2
`define SFRE_LANES_4        3'h4

`define SFRE_DUMMY_NONE     4'h0
`define SFRE_DUMMY_FAST     4'h8
`define SFRE_DUMMY_DTR_SPI  4'h6
`define SFRE_DUMMY_DTR_QPI  4'h8
`define SFRE_DUMMY_RESET    4'h2

`define SFRE_PARAM_P4       2'h1
`define SFRE_PARAM_P6       2'h2
`define SFRE_PARAM_P8       2'h3
`define SFRE_DUMMY_P4       4'h4
`define SFRE_DUMMY_P6       4'h6
`define SFRE_DUMMY_P8       4'h8

`define SFRE_SKIP_CODE      2'h2

`define SFRE_OE_SINGLE      4'h2
`define SFRE_OE_DUAL        4'h3
`define SFRE_OE_QUAD        4'hF

`endif

// *** verilog/sfre_pkg.sv ***
// Types shared by the serial flash read engine
package sfre_pkg;

  typedef enum logic [2:0] {
    SFRE_IDLE   = 3'b000,
    SFRE_CMD    = 3'b001,
    SFRE_ADDR   = 3'b010,
    SFRE_MODE   = 3'b011,
    SFRE_DUMMY  = 3'b100,
    SFRE_DATA   = 3'b101,
    SFRE_IGNORE = 3'b110
  } sfre_state_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] addr_lanes;
    logic       addr_dtr;
    logic       has_mode;
    logic [3:0] dummy;
    logic [2:0] data_lanes;
    logic       data_dtr;
  } sfre_cfg_type;

  typedef struct packed {
    logic [3:0] dq;
    logic [3:0] oe;
  } sfre_lanes_type;

endpackage

// *** verilog/sfre_read_engine.sv ***
// Read command engine of a serial NOR flash, sampling the host clock
`include "sfre_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module sfre_read_engine (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RESET,
  input  wire logic       I_SCLK,
  input  wire logic       I_CS_N,
  input  wire logic [3:0] I_DQ,
  input  wire logic       I_BUSY,
  input  wire logic       I_QUAD_EN,
  input  wire logic       I_FOUR_LINE_MODE,
  input  wire logic       I_PARAM_WE,
  input  wire logic [1:0] I_READ_PARAM,
  input  wire logic [7:0] I_MEM_DATA,
  output var  logic [3:0] O_DQ,
  output var  logic [3:0] O_DQ_OE,
  output var  logic [23:0] O_MEM_ADDR,
  output var  logic       O_SKIP_MODE,
  output var  logic       O_DATA_PHASE
);
  import sfre_pkg::*;

  function automatic sfre_cfg_type decode(input logic [7:0] op,
                                          input logic       four_line_command_mode,
                                          input logic       qe,
                                          input logic [3:0] pdum);
    sfre_cfg_type c;
    c = '0;
    c.addr_lanes = `SFRE_LANES_1;
    c.data_lanes = `SFRE_LANES_1;
    if (four_line_command_mode) begin
      c.addr_lanes = `SFRE_LANES_4;
      c.data_lanes = `SFRE_LANES_4;
      case (op)
        `SFRE_OP_FAST: begin
          c.valid = 1'b1;
          c.dummy = pdum;
        end
        `SFRE_OP_DTR_FAST: begin
          c.valid    = 1'b1;
          c.addr_dtr = 1'b1;
          c.data_dtr = 1'b1;
          c.dummy    = `SFRE_DUMMY_DTR_QPI;
        end
        default: c.valid = 1'b0;
      endcase
    end else begin
      case (op)
        `SFRE_OP_READ: begin
          c.valid = 1'b1;
          c.dummy = `SFRE_DUMMY_NONE;
        end
        `SFRE_OP_FAST: begin
          c.valid = 1'b1;
          c.dummy = `SFRE_DUMMY_FAST;
        end
        `SFRE_OP_DTR_FAST: begin
          c.valid    = 1'b1;
          c.addr_dtr = 1'b1;
          c.data_dtr = 1'b1;
          c.dummy    = `SFRE_DUMMY_DTR_SPI;
        end
        `SFRE_OP_DUAL_OUT: begin
          c.valid      = 1'b1;
          c.dummy      = `SFRE_DUMMY_FAST;
          c.data_lanes = `SFRE_LANES_2;
        end
        `SFRE_OP_QUAD_OUT: begin
          c.valid      = qe;
          c.dummy      = `SFRE_DUMMY_FAST;
          c.data_lanes = `SFRE_LANES_4;
        end
        // dual I/O, mode bits fill the four clocks
        `SFRE_OP_DUAL_IO: begin
          c.valid      = 1'b1;
          c.addr_lanes = `SFRE_LANES_2;
          c.has_mode   = 1'b1;
          c.dummy      = `SFRE_DUMMY_NONE;
          c.data_lanes = `SFRE_LANES_2;
        end
        default: c.valid = 1'b0;
      endcase
    end
    return c;
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] sh,
                                           input logic [3:0]  dq,
                                           input logic [2:0]  lanes);
    case (lanes)
      `SFRE_LANES_2: shift_in = {sh[21:0], dq[1:0]};
      `SFRE_LANES_4: shift_in = {sh[19:0], dq};
      default:       shift_in = {sh[22:0], dq[0]};
    endcase
  endfunction

  // Single output uses lane one, the usual serial out line
  function automatic sfre_lanes_type drive(input logic [7:0] b,
                                           input logic [2:0] lanes);
    sfre_lanes_type l;
    case (lanes)
      `SFRE_LANES_2: begin
        l.dq = {2'h0, b[7:6]};
        l.oe = `SFRE_OE_DUAL;
      end
      `SFRE_LANES_4: begin
        l.dq = b[7:4];
        l.oe = `SFRE_OE_QUAD;
      end
      default: begin
        l.dq = {2'h0, b[7], 1'b0};
        l.oe = `SFRE_OE_SINGLE;
      end
    endcase
    return l;
  endfunction

  // Two-stage synchronisers; the first stage never feeds logic, the second and its delayed copy sclk_d_r do
  logic [1:0] sclk_sync_r;
  logic [1:0] cs_sync_r;
  logic [3:0] dq_meta_r;
  logic [3:0] dq_s_r;
  logic       sclk_d_r;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      sclk_sync_r <= 2'h0;
      cs_sync_r   <= 2'h3;
      dq_meta_r   <= 4'h0;
      dq_s_r      <= 4'h0;
      sclk_d_r    <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], I_SCLK};
      cs_sync_r   <= {cs_sync_r[0], I_CS_N};
      dq_meta_r   <= I_DQ;
      dq_s_r      <= dq_meta_r;
      sclk_d_r    <= sclk_sync_r[1];
    end
  end

  logic sclk_s;
  logic cs_high;
  logic rise;
  logic fall;
  assign sclk_s  = sclk_sync_r[1];
  assign cs_high = cs_sync_r[1];
  assign rise    = sclk_s & ~sclk_d_r;
  assign fall    = ~sclk_s & sclk_d_r;

  sfre_state_type state_r, state_nxt;
  sfre_cfg_type   cfg_r, cfg_nxt;
  logic [4:0]     cnt_r, cnt_nxt;
  logic [23:0]    sh_r, sh_nxt;
  logic [23:0]    addr_r, addr_nxt;
  logic [7:0]     out_sh_r, out_sh_nxt;
  logic [3:0]     out_left_r, out_left_nxt;
  sfre_lanes_type lanes_r, lanes_nxt;
  logic           skip_r, skip_nxt;
  logic [3:0]     pdum_r, pdum_nxt;
  logic           data_ph_r, data_ph_nxt;

  always_comb begin
    sfre_cfg_type c;
    logic [23:0]  s;
    logic [7:0]   b;
    logic [3:0]   left;
    c            = '0;
    s            = 24'h0;
    b            = 8'h0;
    left         = 4'h0;
    state_nxt    = state_r;
    cfg_nxt      = cfg_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    addr_nxt     = addr_r;
    out_sh_nxt   = out_sh_r;
    out_left_nxt = out_left_r;
    lanes_nxt    = lanes_r;
    skip_nxt     = skip_r;
    pdum_nxt     = pdum_r;
    // parameter encoding, code 00 leaves the count unchanged
    if (I_PARAM_WE) begin
      case (I_READ_PARAM)
        `SFRE_PARAM_P4: pdum_nxt = `SFRE_DUMMY_P4;
        `SFRE_PARAM_P6: pdum_nxt = `SFRE_DUMMY_P6;
        `SFRE_PARAM_P8: pdum_nxt = `SFRE_DUMMY_P8;
        default:        pdum_nxt = pdum_r;
      endcase
    end
    case (state_r)
      SFRE_IDLE: begin
        if (!cs_high) begin
          // skip mode goes straight to the address
          if (skip_r) begin
            cfg_nxt   = decode(`SFRE_OP_DUAL_IO, 1'b0, I_QUAD_EN, pdum_r);
            cnt_nxt   = `SFRE_ADDR_BITS;
            state_nxt = SFRE_ADDR;
          end else begin
            cnt_nxt   = `SFRE_CMD_BITS;
            state_nxt = SFRE_CMD;
          end
        end
      end
      SFRE_CMD: begin
        if (rise) begin
          s      = shift_in(sh_r, dq_s_r,
                            I_FOUR_LINE_MODE ? `SFRE_LANES_4
                                             : `SFRE_LANES_1);
          sh_nxt = s;
          if (cnt_r == {2'h0, (I_FOUR_LINE_MODE ? `SFRE_LANES_4
                                                : `SFRE_LANES_1)}) begin
            c = decode(s[7:0], I_FOUR_LINE_MODE, I_QUAD_EN, pdum_r);
            // busy makes the read a no-op
            if (I_BUSY || !c.valid) begin
              state_nxt = SFRE_IGNORE;
            end else begin
              cfg_nxt   = c;
              cnt_nxt   = `SFRE_ADDR_BITS;
              state_nxt = SFRE_ADDR;
            end
          end else begin
            cnt_nxt = cnt_r - {2'h0, (I_FOUR_LINE_MODE ? `SFRE_LANES_4
                                                       : `SFRE_LANES_1)};
          end
        end
      end
      SFRE_ADDR: begin
        // address capture, both edges when double rate
        if (rise || (cfg_r.addr_dtr && fall)) begin
          s      = shift_in(sh_r, dq_s_r, cfg_r.addr_lanes);
          sh_nxt = s;
          if (cnt_r == {2'h0, cfg_r.addr_lanes}) begin
            addr_nxt     = s;
            out_left_nxt = 4'h0;
            if (cfg_r.has_mode) begin
              cnt_nxt   = `SFRE_MODE_BITS;
              state_nxt = SFRE_MODE;
            end else if (cfg_r.dummy == `SFRE_DUMMY_NONE) begin
              state_nxt = SFRE_DATA;
            end else begin
              cnt_nxt   = {1'b0, cfg_r.dummy};
              state_nxt = SFRE_DUMMY;
            end
          end else begin
            cnt_nxt = cnt_r - {2'h0, cfg_r.addr_lanes};
          end
        end
      end
      SFRE_MODE: begin
        // eight mode bits, lower nibble unused
        if (rise) begin
          s      = shift_in(sh_r, dq_s_r, cfg_r.addr_lanes);
          sh_nxt = s;
          if (cnt_r == {2'h0, cfg_r.addr_lanes}) begin
            // mode bits 5:4 decide the next frame
            skip_nxt  = (s[5:4] == `SFRE_SKIP_CODE);
            state_nxt = SFRE_DATA;
          end else begin
            cnt_nxt = cnt_r - {2'h0, cfg_r.addr_lanes};
          end
        end
      end
      SFRE_DUMMY: begin
        // count dummy clocks, lanes stay released
        if (rise) begin
          if (cnt_r == 5'h01) begin
            state_nxt = SFRE_DATA;
          end else begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
      end
      SFRE_DATA: begin
        // first bits on a falling edge, MSB first
        if (fall || (cfg_r.data_dtr && rise)) begin
          b    = (out_left_r == 4'h0) ? I_MEM_DATA : out_sh_r;
          left = (out_left_r == 4'h0) ? `SFRE_BYTE_BITS : out_left_r;
          lanes_nxt    = drive(b, cfg_r.data_lanes);
          out_sh_nxt   = b << cfg_r.data_lanes;
          out_left_nxt = left - {1'b0, cfg_r.data_lanes};
          // next address once the byte is out
          if (left == {1'b0, cfg_r.data_lanes}) begin
            addr_nxt = addr_r + 24'h000001;
          end
        end
      end
      SFRE_IGNORE: begin
        state_nxt = SFRE_IGNORE;
      end
      default: begin
        state_nxt = SFRE_IDLE;
      end
    endcase
    // select high aborts and releases every lane
    if (cs_high) begin
      state_nxt    = SFRE_IDLE;
      lanes_nxt    = '0;
      out_left_nxt = 4'h0;
    end
    data_ph_nxt = (state_nxt == SFRE_DATA);
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      state_r    <= SFRE_IDLE;
      cfg_r      <= '0;
      cnt_r      <= 5'h00;
      sh_r       <= 24'h000000;
      addr_r     <= 24'h000000;
      out_sh_r   <= 8'h00;
      out_left_r <= 4'h0;
      lanes_r    <= '0;
      skip_r     <= 1'b0;
      pdum_r     <= `SFRE_DUMMY_RESET;
      data_ph_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cfg_r      <= cfg_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      addr_r     <= addr_nxt;
      out_sh_r   <= out_sh_nxt;
      out_left_r <= out_left_nxt;
      lanes_r    <= lanes_nxt;
      skip_r     <= skip_nxt;
      pdum_r     <= pdum_nxt;
      data_ph_r  <= data_ph_nxt;
    end
  end

  assign O_DQ         = lanes_r.dq;
  assign O_DQ_OE      = lanes_r.oe;
  assign O_MEM_ADDR   = addr_r;
  assign O_SKIP_MODE  = skip_r;
  assign O_DATA_PHASE = data_ph_r;

endmodule

`default_nettype wire
